// ==== wdr_watchdog_reset_timer.sv ====
// Purpose: watchdog reset timer with APB register access
// Assumes: i_ref_clk is the crystal clock; i_sys_rst is the power-on reset
// Notes: service register sits at the top index and reads the reset vector low byte
//
// Chosen here: the APB register port.
`timescale 1ns/1ps

// Notes on behaviour
// - Prescaler runs on the crystal clock
// - Stop instruction clears the whole prescaler
// - Service write clears counter and upper prescaler
// - Service register reads reset vector low byte
// - Prescaler cleared 4096 cycles after power-up
// - Internal reset clears prescaler and counter
// - Reset vector fetch clears the prescaler
// - Disable comes straight from option bit
// - Rate select comes straight from option bit
// - Watchdog never raises an interrupt request
// - Monitor mode with test voltage disables
// - Counting continues in wait mode
// - Stop mode halts count, clears prescaler
// - Stop enable option gates stop instruction
// - Break with test voltage on reset disables
// - Six-bit counter behind twelve-bit prescaler
// - Overflow after selected cycle count forces reset
// - Reset pin low 32 cycles, cause flag set
module wdr_watchdog_reset_timer (
	input  wire logic                     i_ref_clk,
	input  wire logic                     i_sys_rst,
	input  wire wdr_pkg::wdr_apb_req_type i_apb,
	output wdr_pkg::wdr_apb_rsp_type      o_apb,
	input  wire logic [7:0]               i_reset_vector_lo,
	input  wire logic                     i_stop_exec,
	input  wire logic                     i_stop_mode,
	input  wire logic                     i_wait_mode,
	input  wire logic                     i_vector_fetch,
	input  wire logic                     i_internal_reset,
	input  wire logic                     i_monitor_mode,
	input  wire logic                     i_break_state,
	input  wire logic                     i_irq_high_voltage,
	input  wire logic                     i_rst_high_voltage,
	input  wire logic                     i_rst_pin,
	output logic                          o_rst_pin,
	output logic                          o_rst_pin_oe,
	output logic                          o_wdt_reset,
	output logic                          o_stop_enable,
	output logic                          o_irq_req
);
	import wdr_pkg::*;

	wdr_main_state_type state_r;
	wdr_main_state_type state_nxt;

	logic               access;
	logic               setup;
	logic               hit_option;
	logic               hit_status;
	logic               hit_service;
	logic               mapped;
	logic               svc_wr;
	logic               watchdog_off;
	logic               stop_ok;
	logic               in_stop;
	logic               por_clr;
	logic               clr_all;
	logic               clr_presc;
	logic               overflow;
	logic               pulse_start;
	logic               pulse_active;
	logic [CHAIN_W-1:0] chain;
	logic [31:0]        status_word;

	// Address decode
	assign access      = i_apb.psel && i_apb.penable;
	assign setup       = i_apb.psel && !i_apb.penable;
	assign hit_option  = i_apb.paddr == wdr_byte_addr(IDX_OPTION);
	assign hit_status  = i_apb.paddr == wdr_byte_addr(IDX_STATUS);
	assign hit_service = i_apb.paddr == wdr_byte_addr(IDX_SERVICE);
	assign mapped      = hit_option || hit_status || hit_service;
	// Any data value counts as a service
	assign svc_wr      = access && i_apb.pwrite && hit_service;

	// Disable sources
	assign watchdog_off = state_r.opt.watchdog_disable ||
		(i_monitor_mode && (i_irq_high_voltage || i_rst_high_voltage)) ||
		(i_break_state && i_rst_high_voltage);

	// Stop is only honoured when the option allows it
	assign stop_ok = i_stop_exec && state_r.opt.stop_enable;
	assign in_stop = i_stop_mode && state_r.opt.stop_enable;

	assign por_clr   = !state_r.por_done && (state_r.por_cnt == POR_LAST);
	assign clr_all   = i_internal_reset || pulse_active || watchdog_off;
	assign clr_presc = stop_ok || i_vector_fetch || por_clr;

	assign pulse_start = overflow && !watchdog_off;

	assign status_word = {state_r.cause, 5'h00, i_rst_pin, !watchdog_off, 6'h00, chain};

	// The chain runs on the crystal clock; wait mode does not hold it
	wdr_chain u_chain (
		.i_ref_clk     (i_ref_clk),
		.i_sys_rst     (i_sys_rst),
		.i_clr_all     (clr_all),
		.i_clr_service (svc_wr),
		.i_clr_presc   (clr_presc),
		.i_hold        (in_stop),
		.i_rate_short  (state_r.opt.watchdog_rate_select),
		.o_chain       (chain),
		.o_overflow    (overflow)
	);

	wdr_pulse u_pulse (
		.i_ref_clk (i_ref_clk),
		.i_sys_rst (i_sys_rst),
		.i_start   (pulse_start),
		.o_active  (pulse_active)
	);

	always_comb begin
		state_nxt = state_r;
		// Count stops at its last value so the clear fires once
		if (por_clr) begin
			state_nxt.por_done = 1'b1;
		end else if (!state_r.por_done) begin
			state_nxt.por_cnt = state_r.por_cnt + 1'b1;
		end
		// Read data is captured in the setup cycle
		if (setup) begin
			state_nxt.rdata = '0;
			if (hit_option) begin
				state_nxt.rdata = {29'h0, state_r.opt};
			end else if (hit_status) begin
				state_nxt.rdata = status_word;
			end else if (hit_service) begin
				state_nxt.rdata = {24'h0, i_reset_vector_lo};
			end
		end
		if (access && i_apb.pwrite && hit_option) begin
			state_nxt.opt = i_apb.pwdata[2:0];
		end
		if (access && i_apb.pwrite && hit_status && i_apb.pwdata[ST_CAUSE_BIT]) begin
			state_nxt.cause = 1'b0;
		end
		// A timeout in the clearing cycle still sets the flag
		if (pulse_start) begin
			state_nxt.cause = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state_r          <= '0;
			state_r.opt      <= OPT_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign o_apb.prdata  = state_r.rdata;
	assign o_apb.pready  = access;
	assign o_apb.pslverr = access && !mapped;

	// Open-drain reset pin: only ever pulled low
	assign o_rst_pin     = 1'b0;
	assign o_rst_pin_oe  = pulse_active;
	assign o_wdt_reset   = pulse_active;
	assign o_stop_enable = state_r.opt.stop_enable;
	assign o_irq_req     = 1'b0;

	property p_service;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		svc_wr |=> chain[CHAIN_W-1:KEEP_LOW] == '0;
	endproperty
	a_service: assert property (p_service) else $error("service write did not clear");

	property p_stop_clear;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		stop_ok |=> chain[PRESC_W-1:0] == '0;
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("stop did not clear prescaler");

	property p_por_clear;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		por_clr |=> (chain[PRESC_W-1:0] == '0) && state_r.por_done && (state_r.por_cnt == POR_LAST);
	endproperty
	a_por_clear: assert property (p_por_clear) else $error("power-up clear wrong");

	property p_int_reset;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_internal_reset |=> chain == '0;
	endproperty
	a_int_reset: assert property (p_int_reset) else $error("internal reset did not clear");

	property p_vec_fetch;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_vector_fetch |=> chain[PRESC_W-1:0] == '0;
	endproperty
	a_vec_fetch: assert property (p_vec_fetch) else $error("vector fetch did not clear");

	property p_disabled;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		state_r.opt.watchdog_disable |=> (chain == '0) && !pulse_start;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled watchdog counting");

	property p_monitor;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_monitor_mode && (i_irq_high_voltage || i_rst_high_voltage) |=> chain == '0;
	endproperty
	a_monitor: assert property (p_monitor) else $error("monitor mode did not disable");

	property p_break;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_break_state && i_rst_high_voltage |=> chain == '0;
	endproperty
	a_break: assert property (p_break) else $error("break state did not disable");

	property p_stop_hold;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		in_stop && !clr_all && !clr_presc && !svc_wr |=> $stable(chain);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("chain moved in stop mode");

	property p_wait_count;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_wait_mode && !in_stop && !clr_all && !clr_presc && !svc_wr
			|=> chain == CHAIN_W'($past(chain) + 1'b1);
	endproperty
	a_wait_count: assert property (p_wait_count) else $error("chain stalled in wait mode");

	property p_timeout;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		pulse_start |=> state_r.cause && o_rst_pin_oe;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout did not reset");

	property p_vec_read;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		setup && hit_service |=> o_apb.prdata == {24'h0, $past(i_reset_vector_lo)};
	endproperty
	a_vec_read: assert property (p_vec_read) else $error("service read wrong");

	property p_no_irq;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		!o_irq_req;
	endproperty
	a_no_irq: assert property (p_no_irq) else $error("watchdog raised an interrupt request");

	property p_pin_low;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		o_rst_pin_oe |-> !o_rst_pin && o_wdt_reset;
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("reset pin not pulled low");

	property p_pulse_clear;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		pulse_active |=> chain == '0;
	endproperty
	a_pulse_clear: assert property (p_pulse_clear) else $error("chain ran during reset pulse");

	property p_short_wrap;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		state_r.opt.watchdog_rate_select && (&chain[SHORT_TOP-1:0]) && !watchdog_off && !pulse_active &&
			!i_internal_reset && !svc_wr && !in_stop |=> o_wdt_reset;
	endproperty
	a_short_wrap: assert property (p_short_wrap) else $error("short timeout missed");

	property p_long_quiet;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		!state_r.opt.watchdog_rate_select && !(&chain) |-> !pulse_start;
	endproperty
	a_long_quiet: assert property (p_long_quiet) else $error("long rate timed out early");

	property p_opt_write;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		access && i_apb.pwrite && hit_option |=> state_r.opt == 3'($past(i_apb.pwdata));
	endproperty
	a_opt_write: assert property (p_opt_write) else $error("option bits not taken");

	property p_cause_clear;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		access && i_apb.pwrite && hit_status && i_apb.pwdata[ST_CAUSE_BIT] && !pulse_start |=> !state_r.cause;
	endproperty
	a_cause_clear: assert property (p_cause_clear) else $error("cause flag not cleared");

	property p_por_stay;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		state_r.por_done |=> state_r.por_done && !por_clr;
	endproperty
	a_por_stay: assert property (p_por_stay) else $error("power-up clear repeated");

	property p_stop_gate;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_stop_mode && !state_r.opt.stop_enable && !clr_all && !clr_presc && !svc_wr
			|=> chain == CHAIN_W'($past(chain) + 1'b1);
	endproperty
	a_stop_gate: assert property (p_stop_gate) else $error("stop honoured while not enabled");

	c_service: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) svc_wr);
	c_timeout: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) pulse_start);
	c_stop:    cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) stop_ok ##1 in_stop);
	c_por:     cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) por_clr);
	c_wait_to: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) i_wait_mode && pulse_start);

endmodule : wdr_watchdog_reset_timer

// ==== wdr_pkg.sv ====
// Purpose: shared constants, carriers and state types of the watchdog reset timer
// Assumes: one crystal clock, APB with 32-bit data, word-indexed registers
// Notes: byte address of a register is four times its index
package wdr_pkg;

	localparam int          PRESC_W       = 12;
	localparam int          CNT_W         = 6;
	localparam int          CHAIN_W       = PRESC_W + CNT_W;
	localparam int          SHORT_TOP     = 13;
	localparam int          KEEP_LOW      = 4;
	localparam int          POR_CLR_CYC   = 4096;
	localparam int          RST_PULSE_CYC = 32;
	localparam logic [11:0] POR_LAST      = 12'(POR_CLR_CYC - 1);
	localparam logic [4:0]  PULSE_LAST    = 5'(RST_PULSE_CYC - 1);
	localparam int          ADDR_W        = 18;
	localparam logic [15:0] IDX_OPTION    = 16'h0000;
	localparam logic [15:0] IDX_STATUS    = 16'h0001;
	localparam logic [15:0] IDX_SERVICE   = 16'hffff;
	localparam logic [2:0]  OPT_RESET     = 3'h0;
	localparam int          ST_ACTIVE_BIT = 24;
	localparam int          ST_PIN_BIT    = 25;
	localparam int          ST_CAUSE_BIT  = 31;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} wdr_apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} wdr_apb_rsp_type;

	// Bit 2 stop enable, bit 1 rate select, bit 0 disable
	typedef struct packed {
		logic stop_enable;
		logic watchdog_rate_select;
		logic watchdog_disable;
	} wdr_option_type;

	typedef struct packed {
		logic [CHAIN_W-1:0] chain;
	} wdr_chain_state_type;

	typedef struct packed {
		logic       active;
		logic [4:0] cnt;
	} wdr_pulse_state_type;

	typedef struct packed {
		wdr_option_type opt;
		logic           cause;
		logic [11:0]    por_cnt;
		logic           por_done;
		logic [31:0]    rdata;
	} wdr_main_state_type;

	function automatic logic [ADDR_W-1:0] wdr_byte_addr(input logic [15:0] idx);
		return {idx, 2'b00};
	endfunction : wdr_byte_addr

endpackage : wdr_pkg

// ==== wdr_chain.sv ====
// Purpose: 12-bit prescaler feeding a 6-bit counter, one 18-bit chain
// Assumes: clears may arrive together; each zeroes its own bits, so together they clear the union of their bits
// Notes: overflow is a one-cycle pulse at the wrap of the selected length
`timescale 1ns/1ps
module wdr_chain (
	input  wire logic                        i_ref_clk,
	input  wire logic                        i_sys_rst,
	input  wire logic                        i_clr_all,
	input  wire logic                        i_clr_service,
	input  wire logic                        i_clr_presc,
	input  wire logic                        i_hold,
	input  wire logic                        i_rate_short,
	output logic      [wdr_pkg::CHAIN_W-1:0] o_chain,
	output logic                             o_overflow
);
	import wdr_pkg::*;

	wdr_chain_state_type state_r;
	wdr_chain_state_type state_nxt;
	logic                wrap_long;
	logic                wrap_short;

	assign wrap_long  = &state_r.chain;
	assign wrap_short = &state_r.chain[SHORT_TOP-1:0];

	always_comb begin
		state_nxt = state_r;
		if (!i_hold) begin
			state_nxt.chain = state_r.chain + 1'b1;
		end
		if (i_clr_presc) begin
			state_nxt.chain[PRESC_W-1:0] = '0;
		end
		if (i_clr_service) begin
			state_nxt.chain[CHAIN_W-1:KEEP_LOW] = '0;
		end
		if (i_clr_all) begin
			state_nxt.chain = '0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign o_chain    = state_r.chain;
	// Rate 1 wraps the low 13 bits, rate 0 the full chain
	assign o_overflow = !i_hold && !i_clr_all && !i_clr_service &&
		(i_rate_short ? wrap_short : wrap_long);

	property p_rate_len;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		o_overflow |-> (i_rate_short ? (&o_chain[SHORT_TOP-1:0]) : (&o_chain));
	endproperty
	a_rate_len: assert property (p_rate_len) else $error("overflow at wrong chain value");

endmodule : wdr_chain

// ==== wdr_pulse.sv ====
// Purpose: stretch a watchdog timeout into a fixed low pulse on the reset pin
// Assumes: a start during a running pulse is ignored
// Notes: active for exactly the pulse length in crystal cycles
`timescale 1ns/1ps
module wdr_pulse (
	input  wire logic i_ref_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_start,
	output logic      o_active
);
	import wdr_pkg::*;

	wdr_pulse_state_type state_r;
	wdr_pulse_state_type state_nxt;

	always_comb begin
		state_nxt = state_r;
		if (state_r.active) begin
			state_nxt.cnt = state_r.cnt + 1'b1;
			if (state_r.cnt == PULSE_LAST) begin
				state_nxt.active = 1'b0;
			end
		end else if (i_start) begin
			state_nxt.active = 1'b1;
			state_nxt.cnt    = '0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign o_active = state_r.active;

	property p_pulse_len;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		$fell(o_active) |-> $past(state_r.cnt) == PULSE_LAST;
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");

endmodule : wdr_pulse

// ==== tb_wdr_watchdog_reset_timer.sv ====
// Purpose: self-checking bench of the watchdog reset timer through its APB port and control pins
// Assumes: 10 MHz crystal clock, zero-wait APB slave, short rate gives an 8192-cycle timeout
// Notes: the long rate is only checked for staying quiet over one short period
`timescale 1ns/1ps
module tb_wdr_watchdog_reset_timer;
	import wdr_pkg::*;

	localparam logic [17:0] A_OPT  = 18'h00000;
	localparam logic [17:0] A_STAT = 18'h00004;
	localparam logic [17:0] A_SVC  = 18'h3fffc;
	localparam logic [17:0] A_BAD  = 18'h00010;

	logic            clk;
	logic            rst;
	wdr_apb_req_type apb;
	wdr_apb_rsp_type rsp;
	logic [7:0]      vec;
	logic            stop_exec, stop_mode, wait_mode, vfetch, int_rst;
	logic            mon, brk, irq_hv, rst_hv, rst_pin;
	logic            pin, pin_oe, wdt_rst, stop_en, irq;
	int              failures;
	int              n_compared;
	int              cnt;
	logic [31:0]     rd;
	logic [31:0]     rd1;
	logic            err;
	// Option bits, monitor, break, irq test voltage, reset test voltage, reset expected
	logic [7:0]      cases [7] = '{8'b011_0000_0, 8'b010_1010_0, 8'b010_1001_0, 8'b010_0101_0,
		8'b010_0110_1, 8'b000_0000_0, 8'b010_1000_1};

	wdr_watchdog_reset_timer DUT (
		.i_ref_clk          (clk),
		.i_sys_rst          (rst),
		.i_apb              (apb),
		.o_apb              (rsp),
		.i_reset_vector_lo  (vec),
		.i_stop_exec        (stop_exec),
		.i_stop_mode        (stop_mode),
		.i_wait_mode        (wait_mode),
		.i_vector_fetch     (vfetch),
		.i_internal_reset   (int_rst),
		.i_monitor_mode     (mon),
		.i_break_state      (brk),
		.i_irq_high_voltage (irq_hv),
		.i_rst_high_voltage (rst_hv),
		.i_rst_pin          (rst_pin),
		.o_rst_pin          (pin),
		.o_rst_pin_oe       (pin_oe),
		.o_wdt_reset        (wdt_rst),
		.o_stop_enable      (stop_en),
		.o_irq_req          (irq)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic results;
		$display("Compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic xfer(input logic wr, input logic [17:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk);
		apb <= '{1'b1, 1'b0, wr, a, wd};
		@(posedge clk);
		apb.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		if (rsp.pready !== 1'b1) begin
			failures++;
			results();
		end
		rd = rsp.prdata;
		err = rsp.pslverr;
		apb <= '0;
	endtask : xfer

	task automatic wait_rst(input int lim);
		cnt = 0;
		while (wdt_rst !== 1'b1 && cnt < lim) begin
			@(posedge clk);
			cnt++;
		end
	endtask : wait_rst

	task automatic pulse_width;
		cnt = 0;
		while (wdt_rst === 1'b1 && cnt < 40) begin
			chk({pin_oe, pin, irq}, 3'b100);
			@(posedge clk);
			cnt++;
		end
	endtask : pulse_width

	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		results();
	end

	initial begin
		failures = 0;
		n_compared = 0;
		rst = 1'b1;
		apb = '0;
		vec = 8'h00;
		{stop_exec, stop_mode, wait_mode, vfetch, int_rst} = '0;
		{mon, brk, irq_hv, rst_hv, rst_pin} = '0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		// Let the power-up prescaler clear pass before any timeout is timed
		repeat (4096) @(posedge clk);
		xfer(1'b0, A_OPT, 32'h0);
		chk(rd, 32'h0);
		xfer(1'b0, A_STAT, 32'h0);
		chk(rd[24], 1'b1);
		vec <= 8'h5a;
		xfer(1'b1, A_SVC, 32'hffffffff);
		xfer(1'b0, A_SVC, 32'h0);
		chk(rd, 32'h5a);
		xfer(1'b0, A_BAD, 32'h0);
		chk(rd, 32'h0);
		chk(err, 1'b1);
		xfer(1'b1, A_BAD, 32'h7);
		rst_pin <= 1'b1;
		xfer(1'b0, A_OPT, 32'h0);
		chk(rd, 32'h0);
		xfer(1'b0, A_STAT, 32'h0);
		chk(rd[25], 1'b1);
		xfer(1'b1, A_OPT, 32'h2);
		xfer(1'b0, A_OPT, 32'h0);
		chk(rd, 32'h2);
		// Timeout from a service write, with wait mode on throughout
		wait_mode <= 1'b1;
		xfer(1'b1, A_SVC, 32'h0);
		xfer(1'b0, A_STAT, 32'h0);
		chk(rd[17:6], 12'h0);
		xfer(1'b1, A_SVC, 32'h0);
		wait_rst(9000);
		chk(cnt >= 8170 && cnt <= 8200, 1'b1);
		pulse_width();
		chk(cnt, 32);
		wait_mode <= 1'b0;
		xfer(1'b0, A_STAT, 32'h0);
		chk(rd[31], 1'b1);
		xfer(1'b1, A_STAT, 32'h80000000);
		xfer(1'b0, A_STAT, 32'h0);
		chk(rd[31], 1'b0);
		for (int i = 0; i < 7; i++) begin
			xfer(1'b1, A_OPT, {29'h0, cases[i][7:5]});
			{mon, brk, irq_hv, rst_hv} <= cases[i][4:1];
			xfer(1'b1, A_SVC, 32'h0);
			wait_rst(8300);
			chk(wdt_rst, cases[i][0]);
			pulse_width();
			{mon, brk, irq_hv, rst_hv} <= 4'h0;
		end
		// Stop with stop enabled halts the chain with the prescaler cleared
		xfer(1'b1, A_OPT, 32'h6);
		@(posedge clk);
		chk(stop_en, 1'b1);
		xfer(1'b1, A_SVC, 32'h0);
		stop_mode <= 1'b1;
		stop_exec <= 1'b1;
		@(posedge clk);
		stop_exec <= 1'b0;
		xfer(1'b0, A_STAT, 32'h0);
		chk(rd[11:0], 12'h0);
		rd1 = rd;
		xfer(1'b0, A_STAT, 32'h0);
		chk(rd[17:0], rd1[17:0]);
		xfer(1'b1, A_OPT, 32'h2);
		xfer(1'b0, A_STAT, 32'h0);
		rd1 = rd;
		xfer(1'b0, A_STAT, 32'h0);
		chk(rd[17:0] != rd1[17:0], 1'b1);
		stop_mode <= 1'b0;
		xfer(1'b1, A_SVC, 32'h0);
		vfetch <= 1'b1;
		xfer(1'b0, A_STAT, 32'h0);
		chk(rd[11:0], 12'h0);
		vfetch <= 1'b0;
		int_rst <= 1'b1;
		xfer(1'b0, A_STAT, 32'h0);
		chk(rd[17:0], 18'h0);
		int_rst <= 1'b0;
		results();
	end

endmodule : tb_wdr_watchdog_reset_timer
